// file: io_block_pkg.sv
// Operation
// - cell has buffer plus input, output, enable registers
// - cell works as input, output or bidirectional
// - block has three cells, 21 fabric signals
// - each cell returns registered/combinational plus combinational input
// - row blocks drive all routes, column only column
// - six dedicated clock lines feed the cell registers
// - each cell selects its own clocks and controls
// - input register has own clock and enable
// - output and enable registers share clock, enable
// - two combinational input paths, each own delay
// - differing combinational delays disable input register
// - delays on pin-to-fabric, pin-to-register, register-to-pin
// - one shared clear/preset source, kind chosen per cell
// - power-up level pairs with clear or preset
// - all cell registers use the same async signal
// - synchronous reset acts on active clock edge
package io_block_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_CELLS  = 3;
	localparam int NUM_IOCLK  = 6;
	localparam int DLY_W      = 2;
	localparam int CFG_W      = 25;
	localparam int ADDR_W     = 12;

	// ==========================================================
	// cell modes
	typedef enum logic [1:0] {
		MODE_INPUT  = 2'h0,
		MODE_OUTPUT = 2'h1,
		MODE_BIDIR  = 2'h2
	} mode_type;

	// ==========================================================
	// cell configuration word layout
	localparam int MODE_LSB      = 0;
	localparam int CLKIN_LSB     = 2;
	localparam int CLKOUT_LSB    = 5;
	localparam int CEIN_LOC_BIT  = 8;
	localparam int CEOUT_LOC_BIT = 9;
	localparam int OE_LOC_BIT    = 10;
	localparam int ACLR_EN_BIT   = 11;
	localparam int SCLR_EN_BIT   = 12;
	localparam int PRESET_BIT    = 13;
	localparam int INREG_BIT     = 14;
	localparam int OUTREG_BIT    = 15;
	localparam int OEREG_BIT     = 16;
	localparam int DLY_C0_LSB    = 17;
	localparam int DLY_C1_LSB    = 19;
	localparam int DLY_IN_LSB    = 21;
	localparam int DLY_OUT_LSB   = 23;
	localparam logic [2:0] CLK_SEL_LOCAL = 3'h6;
	localparam logic [CFG_W-1:0] CFG_RST = 25'h0000000;

	// ==========================================================
	// register map
	localparam logic [ADDR_W-1:0] OFS_CFG0   = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CFG1   = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_CFG2   = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h010;
	localparam int CTRL_ROW_BIT  = 0;
	localparam logic CTRL_ROW_RST = 1'h1;
	localparam int ST_PIN_LSB    = 0;
	localparam int ST_INREG_LSB  = 3;
	localparam int ST_OUTREG_LSB = 6;
	localparam int ST_OEREG_LSB  = 9;
	localparam int ST_UNAV_LSB   = 12;

endpackage

// file: pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
module pin_cell (
	input  wire logic                            clk,
	input  wire logic                            srst,
	input  wire logic [io_block_pkg::CFG_W-1:0]  cfg,
	input  wire logic                            cfg_load,
	input  wire logic                            pin_lvl,
	input  wire logic [io_block_pkg::NUM_IOCLK-1:0] io_clk_edge,
	input  wire logic                            local_clk_edge,
	input  wire logic                            dataout,
	input  wire logic                            coe,
	input  wire logic                            cce_in,
	input  wire logic                            cce_out,
	input  wire logic                            caclr,
	input  wire logic                            csclr,
	output logic                                 pin_out,
	output logic                                 pin_oe,
	output logic                                 datain,
	output logic                                 comb_datain,
	output logic                                 in_reg_q,
	output logic                                 out_reg_q,
	output logic                                 oe_reg_q,
	output logic                                 in_unavail
);

	// ==========================================================
	// helpers
	function automatic logic clk_pick(input logic [2:0] sel,
		input logic [io_block_pkg::NUM_IOCLK-1:0] ded,
		input logic loc);
		logic r;
		r = 1'b0;
		if (sel == io_block_pkg::CLK_SEL_LOCAL)
			r = loc;
		else if (sel < 3'(io_block_pkg::NUM_IOCLK))
			r = ded[sel];
		return r;
	endfunction

	function automatic logic tap_pick(input logic [3:0] line,
		input logic [io_block_pkg::DLY_W-1:0] sel);
		return line[sel];
	endfunction

	// ==========================================================
	// control selection
	logic [1:0] mode;
	logic       in_edge, out_edge, ce_in, ce_out, aclr, sclr, init_v;
	logic       oe_src, oe_val, out_val;
	logic [2:0] pin_hist_r, out_hist_r;
	logic [1:0] d_c0, d_c1, d_in, d_out;

	assign mode     = cfg[io_block_pkg::MODE_LSB +: 2];
	assign in_edge  = clk_pick(cfg[io_block_pkg::CLKIN_LSB +: 3],
		io_clk_edge, local_clk_edge);
	assign out_edge = clk_pick(cfg[io_block_pkg::CLKOUT_LSB +: 3],
		io_clk_edge, local_clk_edge);
	assign ce_in    = cfg[io_block_pkg::CEIN_LOC_BIT] ? cce_in : 1'b1;
	assign ce_out   = cfg[io_block_pkg::CEOUT_LOC_BIT] ? cce_out : 1'b1;
	assign oe_src   = cfg[io_block_pkg::OE_LOC_BIT] ? coe : 1'b1;
	assign aclr     = cfg[io_block_pkg::ACLR_EN_BIT] & caclr;
	assign sclr     = cfg[io_block_pkg::SCLR_EN_BIT] & csclr;
	assign init_v   = cfg[io_block_pkg::PRESET_BIT];
	assign d_c0     = cfg[io_block_pkg::DLY_C0_LSB +: 2];
	assign d_c1     = cfg[io_block_pkg::DLY_C1_LSB +: 2];
	assign d_in     = cfg[io_block_pkg::DLY_IN_LSB +: 2];
	assign d_out    = cfg[io_block_pkg::DLY_OUT_LSB +: 2];

	// ==========================================================
	// delay lines
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_hist_r <= 3'h0;
			out_hist_r <= 3'h0;
		end else begin
			pin_hist_r <= {pin_hist_r[1:0], pin_lvl};
			out_hist_r <= {out_hist_r[1:0], out_val};
		end
	end

	// ==========================================================
	// input register
	always_ff @(posedge clk) begin
		if (srst || cfg_load)
			in_reg_q <= init_v;
		else if (aclr)
			in_reg_q <= init_v;
		else if (in_edge && ce_in) begin
			if (sclr)
				in_reg_q <= init_v;
			else
				in_reg_q <= tap_pick({pin_hist_r, pin_lvl}, d_in);
		end
	end

	// ==========================================================
	// output and enable registers
	always_ff @(posedge clk) begin
		if (srst || cfg_load) begin
			out_reg_q <= init_v;
			oe_reg_q  <= init_v;
		end else if (aclr) begin
			out_reg_q <= init_v;
			oe_reg_q  <= init_v;
		end else if (out_edge && ce_out) begin
			out_reg_q <= sclr ? init_v : dataout;
			oe_reg_q  <= sclr ? init_v : oe_src;
		end
	end

	assign out_val = cfg[io_block_pkg::OUTREG_BIT] ? out_reg_q : dataout;
	assign in_unavail = (d_c0 != d_c1);

	always_comb begin
		case (mode)
			io_block_pkg::MODE_INPUT:  oe_val = 1'b0;
			io_block_pkg::MODE_OUTPUT: oe_val = 1'b1;
			io_block_pkg::MODE_BIDIR:
				oe_val = cfg[io_block_pkg::OEREG_BIT] ? oe_reg_q : oe_src;
			default:                   oe_val = 1'b0;
		endcase
	end

	// ==========================================================
	// pin and fabric outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_out     <= 1'b0;
			pin_oe      <= 1'b0;
			datain      <= 1'b0;
			comb_datain <= 1'b0;
		end else begin
			pin_oe  <= oe_val;
			pin_out <= oe_val & tap_pick({out_hist_r, out_val}, d_out);
			if (cfg[io_block_pkg::INREG_BIT] && !in_unavail)
				datain <= in_reg_q;
			else
				datain <= tap_pick({pin_hist_r, pin_lvl}, d_c0);
			comb_datain <= tap_pick({pin_hist_r, pin_lvl}, d_c1);
		end
	end

endmodule
`default_nettype wire

// file: io_block.sv
`timescale 1ns/10ps
`default_nettype none
module io_block (
	input  wire logic                                  REF_CLK,
	input  wire logic                                  SRST,
	// apb slave
	input  wire logic                                  PSEL,
	input  wire logic                                  PENABLE,
	input  wire logic                                  PWRITE,
	input  wire logic [io_block_pkg::ADDR_W-1:0]       PADDR,
	input  wire logic [31:0]                           PWDATA,
	output logic [31:0]                                PRDATA,
	output logic                                       PREADY,
	output logic                                       PSLVERR,
	// dedicated clock lines
	input  wire logic [io_block_pkg::NUM_IOCLK-1:0]    IO_CLK,
	// fabric side
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    DATAOUT,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    COE,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    CCE_IN,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    CCE_OUT,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    CCLK,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    CACLR,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    CSCLR,
	output logic [io_block_pkg::NUM_CELLS-1:0]         ROW_DATAIN,
	output logic [io_block_pkg::NUM_CELLS-1:0]         ROW_COMB,
	output logic [io_block_pkg::NUM_CELLS-1:0]         COL_DATAIN,
	output logic [io_block_pkg::NUM_CELLS-1:0]         COL_COMB,
	output logic [io_block_pkg::NUM_CELLS-1:0]         LINK_DATAIN,
	output logic [io_block_pkg::NUM_CELLS-1:0]         LINK_COMB,
	// package pins
	input  wire logic [io_block_pkg::NUM_CELLS-1:0]    PIN_IN,
	output logic [io_block_pkg::NUM_CELLS-1:0]         PIN_OUT,
	output logic [io_block_pkg::NUM_CELLS-1:0]         PIN_OE
);

	localparam int NC = io_block_pkg::NUM_CELLS;
	localparam int NK = io_block_pkg::NUM_IOCLK;

	// ==========================================================
	// helpers
	function automatic logic sync_lvl(input logic s2, input logic s3,
		input logic cur);
		return (s2 == s3) ? s3 : cur;
	endfunction

	// ==========================================================
	// pin input synchronisers
	logic [NC-1:0] pin_s1_r;
	logic [NC-1:0] pin_s2_r;
	logic [NC-1:0] pin_s3_r;
	logic [NC-1:0] pin_lvl_r;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
		end else begin
			pin_s1_r <= PIN_IN;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			pin_lvl_r <= '0;
		else
			for (int i = 0; i < NC; i++)
				pin_lvl_r[i] <= sync_lvl(pin_s2_r[i], pin_s3_r[i],
					pin_lvl_r[i]);
	end

	// ==========================================================
	// dedicated clock line synchronisers
	logic [NK-1:0] ck_s1_r;
	logic [NK-1:0] ck_s2_r;
	logic [NK-1:0] ck_s3_r;
	logic [NK-1:0] ck_lvl_r;
	logic [NK-1:0] ck_lvl_nxt;
	logic [NK-1:0] ck_edge;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ck_s1_r <= '0;
			ck_s2_r <= '0;
			ck_s3_r <= '0;
		end else begin
			ck_s1_r <= IO_CLK;
			ck_s2_r <= ck_s1_r;
			ck_s3_r <= ck_s2_r;
		end
	end

	always_comb begin
		for (int i = 0; i < NK; i++)
			ck_lvl_nxt[i] = sync_lvl(ck_s2_r[i], ck_s3_r[i], ck_lvl_r[i]);
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			ck_lvl_r <= '0;
		else
			ck_lvl_r <= ck_lvl_nxt;
	end

	assign ck_edge = ck_lvl_nxt & ~ck_lvl_r;

	// ==========================================================
	// fabric clock edge detect
	logic [NC-1:0] cclk_r;
	logic [NC-1:0] cclk_edge;

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			cclk_r <= '0;
		else
			cclk_r <= CCLK;
	end

	assign cclk_edge = CCLK & ~cclk_r;

	// ==========================================================
	// apb decode
	logic        setup;
	logic        wr_acc;
	logic        hit_cfg0;
	logic        hit_cfg1;
	logic        hit_cfg2;
	logic        hit_status;
	logic        hit_ctrl;
	logic        hit_any;

	assign setup      = PSEL & ~PENABLE;
	assign wr_acc     = PSEL & PENABLE & PWRITE & PREADY;
	assign hit_cfg0   = (PADDR == io_block_pkg::OFS_CFG0);
	assign hit_cfg1   = (PADDR == io_block_pkg::OFS_CFG1);
	assign hit_cfg2   = (PADDR == io_block_pkg::OFS_CFG2);
	assign hit_status = (PADDR == io_block_pkg::OFS_STATUS);
	assign hit_ctrl   = (PADDR == io_block_pkg::OFS_CTRL);
	assign hit_any    = hit_cfg0 | hit_cfg1 | hit_cfg2 | hit_status
		| hit_ctrl;

	// ==========================================================
	// configuration registers
	logic [io_block_pkg::CFG_W-1:0] cfg_r [NC];
	logic [NC-1:0]                  cfg_load_r;
	logic                           row_r;
	logic [NC-1:0]                  cfg_hit;

	assign cfg_hit = {hit_cfg2, hit_cfg1, hit_cfg0};

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			for (int i = 0; i < NC; i++)
				cfg_r[i] <= io_block_pkg::CFG_RST;
		end else if (wr_acc) begin
			for (int i = 0; i < NC; i++)
				if (cfg_hit[i])
					cfg_r[i] <= PWDATA[io_block_pkg::CFG_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			cfg_load_r <= '0;
		else if (wr_acc)
			cfg_load_r <= cfg_hit;
		else
			cfg_load_r <= '0;
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			row_r <= io_block_pkg::CTRL_ROW_RST;
		else if (wr_acc && hit_ctrl)
			row_r <= PWDATA[io_block_pkg::CTRL_ROW_BIT];
	end

	// ==========================================================
	// pin cells
	logic [NC-1:0] datain;
	logic [NC-1:0] comb_datain;
	logic [NC-1:0] in_q;
	logic [NC-1:0] out_q;
	logic [NC-1:0] oe_q;
	logic [NC-1:0] unavail;

	for (genvar g = 0; g < NC; g++) begin : g_cell
		pin_cell u_cell (
			.clk            (REF_CLK),
			.srst           (SRST),
			.cfg            (cfg_r[g]),
			.cfg_load       (cfg_load_r[g]),
			.pin_lvl        (pin_lvl_r[g]),
			.io_clk_edge    (ck_edge),
			.local_clk_edge (cclk_edge[g]),
			.dataout        (DATAOUT[g]),
			.coe            (COE[g]),
			.cce_in         (CCE_IN[g]),
			.cce_out        (CCE_OUT[g]),
			.caclr          (CACLR[g]),
			.csclr          (CSCLR[g]),
			.pin_out        (PIN_OUT[g]),
			.pin_oe         (PIN_OE[g]),
			.datain         (datain[g]),
			.comb_datain    (comb_datain[g]),
			.in_reg_q       (in_q[g]),
			.out_reg_q      (out_q[g]),
			.oe_reg_q       (oe_q[g]),
			.in_unavail     (unavail[g])
		);
	end

	// ==========================================================
	// interconnect routing
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ROW_DATAIN  <= '0;
			ROW_COMB    <= '0;
			COL_DATAIN  <= '0;
			COL_COMB    <= '0;
			LINK_DATAIN <= '0;
			LINK_COMB   <= '0;
		end else begin
			COL_DATAIN  <= datain;
			COL_COMB    <= comb_datain;
			ROW_DATAIN  <= row_r ? datain : '0;
			ROW_COMB    <= row_r ? comb_datain : '0;
			LINK_DATAIN <= row_r ? datain : '0;
			LINK_COMB   <= row_r ? comb_datain : '0;
		end
	end

	// ==========================================================
	// status word
	logic [31:0] status;

	always_comb begin
		status = 32'h0;
		status[io_block_pkg::ST_PIN_LSB +: NC]    = pin_lvl_r;
		status[io_block_pkg::ST_INREG_LSB +: NC]  = in_q;
		status[io_block_pkg::ST_OUTREG_LSB +: NC] = out_q;
		status[io_block_pkg::ST_OEREG_LSB +: NC]  = oe_q;
		status[io_block_pkg::ST_UNAV_LSB +: NC]   = unavail;
	end

	// ==========================================================
	// apb answer
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0;
		if (hit_cfg0)
			rd_nxt[io_block_pkg::CFG_W-1:0] = cfg_r[0];
		else if (hit_cfg1)
			rd_nxt[io_block_pkg::CFG_W-1:0] = cfg_r[1];
		else if (hit_cfg2)
			rd_nxt[io_block_pkg::CFG_W-1:0] = cfg_r[2];
		else if (hit_status)
			rd_nxt = status;
		else if (hit_ctrl)
			rd_nxt[io_block_pkg::CTRL_ROW_BIT] = row_r;
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0;
		end else if (setup) begin
			PREADY  <= 1'b1;
			PSLVERR <= ~hit_any;
			PRDATA  <= PWRITE ? 32'h0 : rd_nxt;
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0;
		end
	end

endmodule
`default_nettype wire

// file: pin_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// board side of the pins: a cell that drives wins the wire,
// otherwise the board holds its own level on the line
module pin_pad_model (
	input  wire logic [io_block_pkg::NUM_CELLS-1:0] pin_out,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0] pin_oe,
	input  wire logic [io_block_pkg::NUM_CELLS-1:0] ext_lvl,
	output logic      [io_block_pkg::NUM_CELLS-1:0] pin_in
);
	always_comb
		for (int i = 0; i < io_block_pkg::NUM_CELLS; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
endmodule
`default_nettype wire

// file: io_block_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker
module io_block_sva (
	input wire logic                               REF_CLK,
	input wire logic                               SRST,
	input wire logic                               PSEL,
	input wire logic                               PENABLE,
	input wire logic [io_block_pkg::ADDR_W-1:0]    PADDR,
	input wire logic [31:0]                        PRDATA,
	input wire logic                               PREADY,
	input wire logic                               PSLVERR,
	input wire logic [io_block_pkg::NUM_CELLS-1:0] PIN_OUT,
	input wire logic [io_block_pkg::NUM_CELLS-1:0] PIN_OE,
	input wire logic [io_block_pkg::NUM_CELLS-1:0] ROW_DATAIN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	a_ready_after_setup:
		assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	a_ready_single:
		assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_ready_cause:
		assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
		else $error("ready without setup");
	a_err_unmapped:
		assert property (PSEL && !PENABLE && PADDR > 12'h010
			|=> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	a_err_mapped:
		assert property (PSEL && !PENABLE && PADDR[1:0] == 2'h0
			&& PADDR <= 12'h010 |=> !PSLVERR)
		else $error("mapped access refused");
	a_err_with_ready:
		assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_idle:
		assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside access");
	a_pin_released:
		assert property ((PIN_OUT & ~PIN_OE) == 3'h0)
		else $error("pin value while not driven");
	a_reset_quiet:
		assert property ($past(SRST) |-> PIN_OE == 3'h0
			&& PIN_OUT == 3'h0 && ROW_DATAIN == 3'h0)
		else $error("outputs not low after reset");
endmodule

bind io_block io_block_sva chk_u (
	.REF_CLK    (REF_CLK),
	.SRST       (SRST),
	.PSEL       (PSEL),
	.PENABLE    (PENABLE),
	.PADDR      (PADDR),
	.PRDATA     (PRDATA),
	.PREADY     (PREADY),
	.PSLVERR    (PSLVERR),
	.PIN_OUT    (PIN_OUT),
	.PIN_OE     (PIN_OE),
	.ROW_DATAIN (ROW_DATAIN)
);
`default_nettype wire

// file: tb_io_block.sv
`timescale 1ns/10ps
`default_nettype none
module tb_io_block;
	localparam int N = io_block_pkg::NUM_CELLS;
	logic                               REF_CLK, SRST, PSEL, PENABLE;
	logic                               PWRITE, PREADY, PSLVERR, er;
	logic [io_block_pkg::ADDR_W-1:0]    PADDR;
	logic [31:0]                        PWDATA, PRDATA, rd;
	logic [io_block_pkg::NUM_IOCLK-1:0] IO_CLK;
	logic [N-1:0]                       DATAOUT, COE, CCE_IN, CCE_OUT;
	logic [N-1:0]                       CCLK, CACLR, CSCLR, ext_lvl;
	logic [N-1:0]                       PIN_IN, PIN_OUT, PIN_OE;
	logic [N-1:0]                       ROW_DATAIN, ROW_COMB, COL_DATAIN;
	logic [N-1:0]                       COL_COMB, LINK_DATAIN, LINK_COMB;
	int                                 errors, checks_done, cyc;

	io_block dut_u (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .IO_CLK(IO_CLK), .DATAOUT(DATAOUT), .COE(COE),
		.CCE_IN(CCE_IN), .CCE_OUT(CCE_OUT), .CCLK(CCLK), .CACLR(CACLR),
		.CSCLR(CSCLR), .ROW_DATAIN(ROW_DATAIN), .ROW_COMB(ROW_COMB),
		.COL_DATAIN(COL_DATAIN), .COL_COMB(COL_COMB),
		.LINK_DATAIN(LINK_DATAIN), .LINK_COMB(LINK_COMB),
		.PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
	pin_pad_model pad_u (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
		.ext_lvl(ext_lvl), .pin_in(PIN_IN));

	// ==========================================================
	// clock and hang guard
	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("mismatch at %0t: run too long", $time);
			stop_test();
		end
	end

	// ==========================================================
	// helpers
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
		input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "read data");
		chk(er, ee, "read error");
	endtask
	task automatic sts();
		apb(1'b0, io_block_pkg::OFS_STATUS, 32'h0);
	endtask
	task automatic tick(input int c);
		CCLK[c] <= 1'b1;
		w(1);
		CCLK[c] <= 1'b0;
		w(3);
	endtask
	function automatic logic [31:0] bt(input int n);
		return 32'h1 << n;
	endfunction
	function automatic logic [31:0] cf(input logic [1:0] m,
		input logic [2:0] ci, co, input logic [31:0] f);
		return 32'(m) | (32'(ci) << io_block_pkg::CLKIN_LSB)
			| (32'(co) << io_block_pkg::CLKOUT_LSB) | f;
	endfunction

	// ==========================================================
	// sequence
	initial begin
		errors = 0;
		checks_done = 0;
		cyc = 0;
		{PSEL, PENABLE, PWRITE, IO_CLK, DATAOUT, COE, CCE_IN} = '0;
		{CCE_OUT, CCLK, CACLR, CSCLR, ext_lvl, PADDR, PWDATA} = '0;
		SRST = 1'b1;
		repeat (10) @(posedge REF_CLK);
		SRST <= 1'b0;
		for (int i = 0; i < 3; i++)
			rdchk(io_block_pkg::OFS_CFG0 + 12'(4 * i), 32'h0, 1'b0);
		rdchk(io_block_pkg::OFS_CTRL, 32'h1, 1'b0);
		rdchk(io_block_pkg::OFS_STATUS, 32'h0, 1'b0);
		apb(1'b1, 12'h014, 32'hffffffff);
		chk(er, 1'b1, "unmapped write");
		rdchk(12'h014, 32'h0, 1'b1);
		apb(1'b1, io_block_pkg::OFS_STATUS, 32'hffffffff);
		rdchk(io_block_pkg::OFS_STATUS, 32'h0, 1'b0);
		DATAOUT <= 3'h1;
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, io_block_pkg::OFS_CFG0, cf(2'(m), 3'h7, 3'h7, 0));
			w(4);
			chk(PIN_OE[0], 1'(m != 0), "enable per mode");
			chk(PIN_OUT[0], 1'(m != 0), "value per mode");
		end
		// bidir with fabric enable, pin level loops back
		apb(1'b1, io_block_pkg::OFS_CFG0, 32'hfe000002
			| bt(io_block_pkg::OE_LOC_BIT));
		rdchk(io_block_pkg::OFS_CFG0, 32'h2 | bt(10), 1'b0);
		w(6);
		chk(PIN_OE[0], 1'b0, "fabric enable low");
		COE[0] <= 1'b1;
		w(8);
		chk({PIN_OE[0], PIN_OUT[0]}, 2'h3, "fabric enable high");
		sts();
		chk(rd[0], 1'b1, "pin level driven");
		// registered output and enable share one clock and enable
		apb(1'b1, io_block_pkg::OFS_CFG0, cf(2'h2, 3'h7, 3'h6,
			bt(15) | bt(16) | bt(10) | bt(9) | bt(11) | bt(12)));
		w(2);
		tick(0);
		sts();
		chk(rd[9] | rd[6], 1'b0, "held without enable");
		CCE_OUT[0] <= 1'b1;
		tick(0);
		sts();
		chk({rd[9], rd[6], PIN_OE[0]}, 3'h7, "shared clock load");
		CSCLR[0] <= 1'b1;
		w(3);
		sts();
		chk(rd[6], 1'b1, "sync clear waits for clock");
		tick(0);
		sts();
		chk(rd[6], 1'b0, "sync clear on clock");
		CSCLR[0] <= 1'b0;
		tick(0);
		CACLR[0] <= 1'b1;
		w(3);
		tick(0);
		sts();
		chk({rd[9], rd[6]}, 2'h0, "async clear wins");
		CACLR[0] <= 1'b0;
		// preset level loads all three registers of a cell
		apb(1'b1, io_block_pkg::OFS_CFG2, cf(2'h1, 3'h7, 3'h7,
			bt(13) | bt(11) | bt(14) | bt(15) | bt(16)));
		CACLR[2] <= 1'b1;
		w(4);
		sts();
		chk(rd & 32'h920, 32'h920, "preset on all regs");
		chk(PIN_OUT[2], 1'b1, "preset drives high");
		CACLR[2] <= 1'b0;
		// input cell on a dedicated clock line
		apb(1'b1, io_block_pkg::OFS_CFG1, cf(2'h0, 3'h2, 3'h6,
			bt(14) | bt(8)));
		ext_lvl[1] <= 1'b1;
		w(8);
		chk({ROW_COMB[1], COL_COMB[1], LINK_COMB[1]}, 3'h7, "comb");
		IO_CLK[2] <= 1'b1;
		w(8);
		sts();
		chk({rd[4], rd[1]}, 2'h1, "input held");
		IO_CLK[2] <= 1'b0;
		CCE_IN[1] <= 1'b1;
		w(4);
		tick(1);
		IO_CLK[2] <= 1'b1;
		w(8);
		sts();
		chk(rd[4], 1'b1, "line clocked input");
		chk({ROW_DATAIN[1], COL_DATAIN[1], LINK_DATAIN[1]}, 3'h7,
			"registered datain");
		apb(1'b1, io_block_pkg::OFS_CFG1, bt(17) | bt(20));
		sts();
		chk(rd[13], 1'b1, "delays differ");
		apb(1'b1, io_block_pkg::OFS_CFG1, bt(17) | bt(19));
		sts();
		chk(rd[13], 1'b0, "delays equal");
		apb(1'b1, io_block_pkg::OFS_CTRL, 32'h0);
		w(8);
		chk({ROW_COMB, LINK_COMB, COL_COMB}, 9'h6, "column block");
		chk({ROW_DATAIN, LINK_DATAIN, COL_DATAIN}, 9'h6, "col datain");
		// output delay taps
		DATAOUT[0] <= 1'b0;
		apb(1'b1, io_block_pkg::OFS_CFG0, cf(2'h1, 3'h7, 3'h7,
			32'h3 << io_block_pkg::DLY_OUT_LSB));
		w(8);
		DATAOUT[0] <= 1'b1;
		w(2);
		chk(PIN_OUT[0], 1'b0, "delay taps hold");
		w(6);
		chk(PIN_OUT[0], 1'b1, "delay taps pass");
		stop_test();
	end
endmodule
`default_nettype wire
